// ---- logic/ptb_timebase.sv ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Fifteen-stage divider chain, eight taps selectable as interrupt source.
// RULE2: Divider clocked by external clock when enabled, else internal clock.
// RULE3: Divider held at zero while timebase enable is clear.
// RULE4: Divider starts counting from zero once timebase enable is set.
// RULE5: Pending flag sets whenever divider overflows at the selected tap.
// RULE6: Interrupt request asserted while pending flag and interrupt enable both set.
// RULE7: Writing one to acknowledge clears pending flag; writing zero does nothing.
// RULE8: Acknowledge bit is write-only and always reads zero.
// RULE9: Pending flag is read-only; one means interrupt pending.
// RULE10: Rate codes 0..7 give 32768,8192,2048,128,64,32,16,1 divider clocks.
// RULE11: Event period equals selected divider over divider clock frequency.
// RULE12: First event after enable comes at about half the period.
// RULE13: Later events come at exactly the selected period.
// RULE14: Software must not change rate select while timebase is enabled.
// RULE15: Counting and events continue in wait mode.
// RULE16: Control register inaccessible to the CPU during wait mode.
// RULE17: Control register inaccessible to the CPU during stop mode.
// RULE18: Block halts in stop mode unless clock run in stop is set.
// RULE19: With clock kept running in stop, counting continues for periodic wakeup.
// RULE20: Reset clears interrupt enable.
// RULE21: Reset clears timebase enable, holding the divider at zero.
// RULE22: Overflow in the same cycle as acknowledge leaves pending flag set.

module ptb_timebase
  import ptb_pkg::*;
#(
  parameter int STAGES = DIVIDER_STAGES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalClock,
  input  wire logic        internalClock,
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  output logic             rolloverIrq
);

  ptb_ctrl_type      ctrl;
  ptb_clkgen_type    clkGen;
  logic              rolloverPendingFlag;
  logic              prevDividerClock;
  logic              dividerClock;
  logic              divTick;
  logic              run;
  logic              rolloverEvent;
  logic [STAGES-1:0] count;
  logic [STAGES-1:0] tapMask;
  logic [STAGES-1:0] tapHalf;
  logic [TAP_WIDTH-1:0] tapExp;
  ptb_reg_type       setupSel;
  ptb_reg_type       accessSel;
  logic              setupPhase;
  logic              accessDone;
  logic              accessBlocked;
  logic              setupError;
  logic              writeControl;
  logic              writeClockGen;
  logic              ackWrite;
  logic [31:0]       readValue;

  // Address decode, shared by the setup and access phases
  function automatic ptb_reg_type reg_select(input logic [7:0] addr);
    ptb_reg_type sel;
    sel = REG_NONE;
    if (addr == TIMEBASE_CONTROL_OFFSET) begin
      sel = REG_CONTROL;
    end else if (addr == CLOCK_GEN_CONTROL_OFFSET) begin
      sel = REG_CLOCK_GEN;
    end else if (addr == DIVIDER_COUNT_OFFSET) begin
      sel = REG_COUNT;
    end
    return sel;
  endfunction : reg_select

  // Rate code to tap exponent
  function automatic logic [TAP_WIDTH-1:0] tap_exponent(input logic [RATE_WIDTH-1:0] rate);
    logic [TAP_WIDTH-1:0] e;
    e = TAP_EXP_0;
    unique case (rate)
      3'h0: e = TAP_EXP_0;
      3'h1: e = TAP_EXP_1;
      3'h2: e = TAP_EXP_2;
      3'h3: e = TAP_EXP_3;
      3'h4: e = TAP_EXP_4;
      3'h5: e = TAP_EXP_5;
      3'h6: e = TAP_EXP_6;
      3'h7: e = TAP_EXP_7;
    endcase
    return e;
  endfunction : tap_exponent

  // Divider clock source and tick
  assign dividerClock = clkGen.externalClockEnable ? externalClock : internalClock; // RULE2

  // Rising edge of the selected source; a source switch may add one tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prevDividerClock <= 1'b0;
    end else begin
      prevDividerClock <= dividerClock;
    end
  end

  assign divTick = dividerClock && !prevDividerClock;

  // Stop mode freezes the chain unless its clock is kept alive; wait mode does not
  assign run = !stopMode || clkGen.clockRunInStop; // RULE15 RULE18 RULE19

  // Tap mask and half point
  assign tapExp = tap_exponent(ctrl.rateSelect); // RULE10

  always_comb begin
    tapMask = '0;
    tapHalf = '0;
    for (int i = 0; i < STAGES; i++) begin
      if (TAP_WIDTH'(i) < tapExp) begin
        tapMask[i] = 1'b1;
      end
      if (TAP_WIDTH'(i + 1) == tapExp) begin
        tapHalf[i] = 1'b1;
      end
    end
  end

  ptb_divider #(
    .STAGES(STAGES)
  ) u_divider (
    .clk          (clk),
    .reset        (reset),
    .ctrl         (ctrl),
    .run          (run),
    .divTick      (divTick),
    .tapMask      (tapMask),
    .tapHalf      (tapHalf),
    .rolloverEvent(rolloverEvent), // RULE1 RULE11
    .count        (count)
  );

  // APB phases
  assign setupPhase    = psel && !penable;
  assign accessDone    = psel && penable && pready;
  assign setupSel      = reg_select(paddr);
  assign accessSel     = reg_select(paddr);
  assign accessBlocked = waitMode || stopMode;
  assign setupError    = (setupSel == REG_NONE) ||
                         ((setupSel == REG_CONTROL) && accessBlocked); // RULE16 RULE17

  // Writes land only at the completing edge of an error-free access
  assign writeControl  = accessDone && pwrite && !pslverr && (accessSel == REG_CONTROL);
  assign writeClockGen = accessDone && pwrite && !pslverr && (accessSel == REG_CLOCK_GEN);
  assign ackWrite      = writeControl && pwdata[ACK_BIT]; // RULE7

  // Zero-wait answer: pready high in the first access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPhase && setupError;
    end
  end

  // Read data assembled from live state
  always_comb begin
    readValue = '0;
    unique case (setupSel)
      REG_CONTROL: begin
        readValue[PENDING_BIT]         = rolloverPendingFlag; // RULE9
        readValue[RATE_MSB:RATE_LSB]   = ctrl.rateSelect;
        readValue[ACK_BIT]             = 1'b0; // RULE8
        readValue[IRQ_EN_BIT]          = ctrl.irqEnable;
        readValue[ENABLE_BIT]          = ctrl.timebaseEnable;
      end
      REG_CLOCK_GEN: begin
        readValue[EXT_CLK_EN_BIT]      = clkGen.externalClockEnable;
        readValue[RUN_IN_STOP_BIT]     = clkGen.clockRunInStop;
      end
      REG_COUNT: begin
        readValue[STAGES-1:0]          = count;
      end
      REG_NONE: begin
        readValue = '0;
      end
    endcase
  end

  // Captured at setup, so a flag set during the access shows next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
    end else if (setupPhase && !pwrite && !setupError) begin
      prdata <= readValue;
    end else begin
      prdata <= '0;
    end
  end

  // Control fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl.rateSelect     <= RATE_RESET;
      ctrl.irqEnable      <= IRQ_EN_RESET; // RULE20
      ctrl.timebaseEnable <= ENABLE_RESET; // RULE21
    end else if (writeControl) begin
      // Rate changes while enabled are accepted as written
      ctrl.rateSelect     <= pwdata[RATE_MSB:RATE_LSB]; // RULE14
      ctrl.irqEnable      <= pwdata[IRQ_EN_BIT];
      ctrl.timebaseEnable <= pwdata[ENABLE_BIT];
    end
  end

  // Clock generator configuration seen by this block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clkGen.externalClockEnable <= EXT_CLK_RESET;
      clkGen.clockRunInStop      <= RUN_STOP_RESET;
    end else if (writeClockGen) begin
      clkGen.externalClockEnable <= pwdata[EXT_CLK_EN_BIT];
      clkGen.clockRunInStop      <= pwdata[RUN_IN_STOP_BIT];
    end
  end

  // Pending flag: a new overflow beats a simultaneous acknowledge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rolloverPendingFlag <= PENDING_RESET;
    end else if (rolloverEvent) begin
      rolloverPendingFlag <= 1'b1; // RULE5 RULE22
    end else if (ackWrite) begin
      rolloverPendingFlag <= 1'b0; // RULE7
    end
  end

  // Request level, one cycle behind the flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rolloverIrq <= 1'b0;
    end else begin
      rolloverIrq <= rolloverPendingFlag && ctrl.irqEnable; // RULE6
    end
  end

endmodule : ptb_timebase

// ---- inc/ptb_pkg.sv ----
package ptb_pkg;

  // Divider chain
  localparam int DIVIDER_STAGES = 15;
  localparam int RATE_WIDTH     = 3;
  localparam int TAP_WIDTH      = 4;

  // Register byte addresses
  localparam logic [7:0] TIMEBASE_CONTROL_OFFSET = 8'h1c;
  localparam logic [7:0] CLOCK_GEN_CONTROL_OFFSET = 8'h20;
  localparam logic [7:0] DIVIDER_COUNT_OFFSET    = 8'h24;

  // timebase_control fields
  localparam int PENDING_BIT   = 7;
  localparam int RATE_MSB      = 6;
  localparam int RATE_LSB      = 4;
  localparam int ACK_BIT       = 3;
  localparam int IRQ_EN_BIT    = 2;
  localparam int ENABLE_BIT    = 1;

  // clock_generator_control fields
  localparam int EXT_CLK_EN_BIT   = 0;
  localparam int RUN_IN_STOP_BIT  = 1;

  // Values after reset
  localparam logic [RATE_WIDTH-1:0] RATE_RESET     = 3'h0;
  localparam logic                  IRQ_EN_RESET   = 1'h0;
  localparam logic                  ENABLE_RESET   = 1'h0;
  localparam logic                  PENDING_RESET  = 1'h0;
  localparam logic                  EXT_CLK_RESET  = 1'h0;
  localparam logic                  RUN_STOP_RESET = 1'h0;

  // Tap exponent per rate code: divider = 2**exponent
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_0 = 4'hf;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_1 = 4'hd;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_2 = 4'hb;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_3 = 4'h7;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_4 = 4'h6;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_5 = 4'h5;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_6 = 4'h4;
  localparam logic [TAP_WIDTH-1:0] TAP_EXP_7 = 4'h0;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_CONTROL,
    REG_CLOCK_GEN,
    REG_COUNT
  } ptb_reg_type;

  typedef struct packed {
    logic [RATE_WIDTH-1:0] rateSelect;
    logic                  irqEnable;
    logic                  timebaseEnable;
  } ptb_ctrl_type;

  typedef struct packed {
    logic externalClockEnable;
    logic clockRunInStop;
  } ptb_clkgen_type;

endpackage : ptb_pkg

// ---- logic/ptb_divider.sv ----
`timescale 1ns/1ps

module ptb_divider
  import ptb_pkg::*;
#(
  parameter int STAGES = DIVIDER_STAGES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire ptb_ctrl_type      ctrl,
  input  wire logic              run,
  input  wire logic              divTick,
  input  wire logic [STAGES-1:0] tapMask,
  input  wire logic [STAGES-1:0] tapHalf,
  output logic                   rolloverEvent,
  output logic      [STAGES-1:0] count
);

  logic [STAGES-1:0] next_count;
  logic              advance;

  assign advance    = ctrl.timebaseEnable && run && divTick;
  assign next_count = count + STAGES'(1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (!ctrl.timebaseEnable) begin
      count <= '0; // RULE3
    end else if (advance) begin
      count <= next_count; // RULE4
    end
  end

  // Tap bit rising: first event after half a period (after one tick at divider 1), then every period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rolloverEvent <= 1'b0;
    end else begin
      rolloverEvent <= advance && ((next_count & tapMask) == tapHalf); // RULE5 RULE12 RULE13
    end
  end

endmodule : ptb_divider

// ---- testbench/ptb_timebase_checker.sv ----
`timescale 1ns/1ps

module ptb_timebase_checker
  import ptb_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        waitMode,
  input wire logic        stopMode,
  input wire logic        rolloverIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire isCtrl    = paddr == TIMEBASE_CONTROL_OFFSET;
  wire setupCtrl = psel && !penable && isCtrl;
  wire wrCtrl    = psel && penable && pready && pwrite && isCtrl;

  property p_ready; psel && !penable |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_wait; setupCtrl && waitMode |=> pslverr && prdata == 32'h0; endproperty
  property p_stop; setupCtrl && stopMode |=> pslverr && prdata == 32'h0; endproperty
  property p_ack;
    pready && !pwrite && isCtrl |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  property p_irq_fall; $fell(rolloverIrq) |-> $past(wrCtrl) || $past(wrCtrl, 2); endproperty

  a_ready: assert property (p_ready) else $error("late ready");
  a_pulse: assert property (p_pulse) else $error("ready held");
  a_err: assert property (p_err) else $error("error without ready");
  a_idle: assert property (p_idle) else $error("read data outside access");
  a_wait: assert property (p_wait) else $error("access open in wait");
  a_stop: assert property (p_stop) else $error("access open in stop");
  a_ack: assert property (p_ack) else $error("acknowledge bit read back");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");

  c_irq: cover property ($rose(rolloverIrq));
  c_err: cover property (pslverr);
  c_wait: cover property (setupCtrl && waitMode);
endmodule : ptb_timebase_checker

// ---- testbench/ptb_timebase_tb_top.sv ----
`timescale 1ns/1ps

module ptb_timebase_tb_top
  import ptb_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, extClk, intClk, waitMode, stopMode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq;
  int          fail_count, checks_done, i;
  int          divTab[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 1};

  ptb_timebase i_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalClock(extClk), .internalClock(intClk),
    .waitMode(waitMode), .stopMode(stopMode), .rolloverIrq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task finish_test;
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        finish_test();
      end
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, expErr});
  endtask : rdc

  // Slow ticks (h=3) leave room for the three-cycle flag pipeline
  task tick(input bit ext, input int n, input int h);
    repeat (n) begin
      if (ext) extClk <= 1'b1;
      else intClk <= 1'b1;
      repeat (h) @(posedge clk);
      extClk <= 1'b0;
      intClk <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask : tick

  task chk_irq(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  initial begin
    {psel, penable, pwrite, extClk, intClk, waitMode, stopMode} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fail_count = 0;
    checks_done = 0;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(TIMEBASE_CONTROL_OFFSET, 32'h0, 1'b0);
    rdc(CLOCK_GEN_CONTROL_OFFSET, 32'h0, 1'b0);
    rdc(8'h30, 32'h0, 1'b1);
    tick(0, 3, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h0, 1'b0);
    wr(TIMEBASE_CONTROL_OFFSET, 32'h66);
    tick(0, 7, 3);
    chk_irq(1'b0);
    tick(0, 1, 3);
    chk_irq(1'b1);
    rdc(TIMEBASE_CONTROL_OFFSET, 32'he6, 1'b0);
    wr(TIMEBASE_CONTROL_OFFSET, 32'h66);
    chk_irq(1'b1);
    wr(TIMEBASE_CONTROL_OFFSET, 32'h6e);
    chk_irq(1'b0);
    tick(0, 15, 3);
    chk_irq(1'b0);
    tick(0, 1, 3);
    chk_irq(1'b1);
    for (i = 0; i < 8; i++) begin
      // Disable first with the old rate kept, then change rate while stopped
      wr(TIMEBASE_CONTROL_OFFSET, {25'h0, (i == 0) ? 3'h6 : 3'(i - 1), 4'h8});
      wr(TIMEBASE_CONTROL_OFFSET, {25'h0, i[2:0], 4'h6});
      tick(0, (divTab[i] == 1) ? 0 : divTab[i] / 2 - 1, 1);
      repeat (6) @(posedge clk);
      chk_irq(1'b0);
      tick(0, 1, 3);
      chk_irq(1'b1);
    end
    wr(TIMEBASE_CONTROL_OFFSET, 32'h78);
    wr(CLOCK_GEN_CONTROL_OFFSET, 32'h1);
    wr(TIMEBASE_CONTROL_OFFSET, 32'h72);
    tick(0, 3, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h0, 1'b0);
    tick(1, 3, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h3, 1'b0);
    chk_irq(1'b0);
    waitMode <= 1'b1;
    rdc(TIMEBASE_CONTROL_OFFSET, 32'h0, 1'b1);
    tick(1, 2, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h5, 1'b0);
    waitMode <= 1'b0;
    stopMode <= 1'b1;
    rdc(TIMEBASE_CONTROL_OFFSET, 32'h0, 1'b1);
    tick(1, 2, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h5, 1'b0);
    wr(CLOCK_GEN_CONTROL_OFFSET, 32'h3);
    tick(1, 2, 3);
    rdc(DIVIDER_COUNT_OFFSET, 32'h7, 1'b0);
    stopMode <= 1'b0;
    // Tick sampled at the setup edge: event and acknowledge meet at the access edge
    extClk <= 1'b1;
    wr(TIMEBASE_CONTROL_OFFSET, 32'h7a);
    extClk <= 1'b0;
    rdc(TIMEBASE_CONTROL_OFFSET, 32'hf2, 1'b0);
    wr(TIMEBASE_CONTROL_OFFSET, 32'h70);
    rdc(DIVIDER_COUNT_OFFSET, 32'h0, 1'b0);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(CLOCK_GEN_CONTROL_OFFSET, 32'h0, 1'b0);
    rdc(TIMEBASE_CONTROL_OFFSET, 32'h0, 1'b0);
    finish_test();
  end
endmodule : ptb_timebase_tb_top

bind ptb_timebase ptb_timebase_checker i_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .waitMode(waitMode), .stopMode(stopMode), .rolloverIrq(rolloverIrq)
);
